// ==== design/iprb_bank.v ====
// ahb-lite slave holding the peripheral interrupt priority fields
`timescale 1ns/1ps
`include "iprb_consts.vh"
module iprb_bank #(
    parameter NUM_FIELDS = 15
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // levels toward arbitration
    output reg [2:0] ext_irq1_level,
    output reg [2:0] timer4_level,
    output reg [2:0] compare4_level,
    output reg [2:0] compare3_level,
    output reg [2:0] uart2_transmit_level,
    output reg [2:0] uart2_receive_level,
    output reg [2:0] ext_irq2_level,
    output reg [2:0] timer5_level,
    output reg [2:0] spi2_event_level,
    output reg [2:0] spi2_fault_level,
    output reg [2:0] capture5_level,
    output reg [2:0] capture4_level,
    output reg [2:0] capture3_level,
    output reg [2:0] compare5_level,
    output reg [2:0] parallel_port_level,
    // one bit per field, same order as levels, high when not disabled
    output reg [14:0] source_active
);
    // field index map: 0 ext1, 1 tmr4, 2 cmp4, 3 cmp3, 4 u2tx, 5 u2rx, 6 ext2,
    // 7 tmr5, 8 spi ev, 9 spi flt, 10 cap5, 11 cap4, 12 cap3, 13 cmp5, 14 pmp
    reg wr_pend_q;
    reg [11:0] wr_addr_q;
    reg [NUM_FIELDS-1:0] fld_wr;
    reg [3*NUM_FIELDS-1:0] fld_wdata;
    wire [3*NUM_FIELDS-1:0] fld_level;
    wire [NUM_FIELDS-1:0] fld_active;
    reg [31:0] rd_d;
    wire acc;

    assign acc = hsel && hready && htrans[1];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIELDS; gi = gi + 1) begin : g_fld
            iprb_field u_fld (
                .hclk(hclk),
                .hresetn(hresetn),
                .clk_en(clk_en),
                .wr_en(fld_wr[gi]),
                .wr_data(fld_wdata[3*gi+2:3*gi]),
                .level_q(fld_level[3*gi+2:3*gi]),
                .active_q(fld_active[gi])
            );
        end
    endgenerate

    // write data phase: route bits to fields by captured address
    always @* begin
        fld_wr = {NUM_FIELDS{1'b0}};
        fld_wdata = {3*NUM_FIELDS{1'b0}};
        if (wr_pend_q) begin
            if (wr_addr_q == `IPRB_OFS_EXT1) begin
                fld_wr[0] = 1'b1;
                fld_wdata[2:0] = hwdata[`IPRB_POS_LO+2:`IPRB_POS_LO];
            end else if (wr_addr_q == `IPRB_OFS_TMR4) begin
                fld_wr[3:1] = 3'h7;
                fld_wdata[5:3] = hwdata[`IPRB_POS_HI+2:`IPRB_POS_HI];
                fld_wdata[8:6] = hwdata[`IPRB_POS_MH+2:`IPRB_POS_MH];
                fld_wdata[11:9] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
            end else if (wr_addr_q == `IPRB_OFS_UART2) begin
                fld_wr[7:4] = 4'hF;
                fld_wdata[14:12] = hwdata[`IPRB_POS_HI+2:`IPRB_POS_HI];
                fld_wdata[17:15] = hwdata[`IPRB_POS_MH+2:`IPRB_POS_MH];
                fld_wdata[20:18] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
                fld_wdata[23:21] = hwdata[`IPRB_POS_LO+2:`IPRB_POS_LO];
            end else if (wr_addr_q == `IPRB_OFS_SPI2) begin
                fld_wr[9:8] = 2'h3;
                fld_wdata[26:24] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
                fld_wdata[29:27] = hwdata[`IPRB_POS_LO+2:`IPRB_POS_LO];
            end else if (wr_addr_q == `IPRB_OFS_CAP) begin
                fld_wr[12:10] = 3'h7;
                fld_wdata[32:30] = hwdata[`IPRB_POS_HI+2:`IPRB_POS_HI];
                fld_wdata[35:33] = hwdata[`IPRB_POS_MH+2:`IPRB_POS_MH];
                fld_wdata[38:36] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
            end else if (wr_addr_q == `IPRB_OFS_CMP5) begin
                fld_wr[13] = 1'b1;
                fld_wdata[41:39] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
            end else if (wr_addr_q == `IPRB_OFS_PMP) begin
                fld_wr[14] = 1'b1;
                fld_wdata[44:42] = hwdata[`IPRB_POS_ML+2:`IPRB_POS_ML];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        rd_d = 32'h00000000;
        if (haddr == `IPRB_OFS_EXT1) begin
            rd_d[`IPRB_POS_LO+2:`IPRB_POS_LO] = fld_level[2:0];
        end else if (haddr == `IPRB_OFS_TMR4) begin
            rd_d[`IPRB_POS_HI+2:`IPRB_POS_HI] = fld_level[5:3];
            rd_d[`IPRB_POS_MH+2:`IPRB_POS_MH] = fld_level[8:6];
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[11:9];
        end else if (haddr == `IPRB_OFS_UART2) begin
            rd_d[`IPRB_POS_HI+2:`IPRB_POS_HI] = fld_level[14:12];
            rd_d[`IPRB_POS_MH+2:`IPRB_POS_MH] = fld_level[17:15];
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[20:18];
            rd_d[`IPRB_POS_LO+2:`IPRB_POS_LO] = fld_level[23:21];
        end else if (haddr == `IPRB_OFS_SPI2) begin
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[26:24];
            rd_d[`IPRB_POS_LO+2:`IPRB_POS_LO] = fld_level[29:27];
        end else if (haddr == `IPRB_OFS_CAP) begin
            rd_d[`IPRB_POS_HI+2:`IPRB_POS_HI] = fld_level[32:30];
            rd_d[`IPRB_POS_MH+2:`IPRB_POS_MH] = fld_level[35:33];
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[38:36];
        end else if (haddr == `IPRB_OFS_CMP5) begin
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[41:39];
        end else if (haddr == `IPRB_OFS_PMP) begin
            rd_d[`IPRB_POS_ML+2:`IPRB_POS_ML] = fld_level[44:42];
        end
    end

    // bus phases; zero wait states, response always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                wr_addr_q <= {haddr[11:2], 2'b00};
            end
            if (acc && !hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

    // levels registered again so outputs stay flop-driven
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_irq1_level <= `IPRB_FIELD_RESET;
            timer4_level <= `IPRB_FIELD_RESET;
            compare4_level <= `IPRB_FIELD_RESET;
            compare3_level <= `IPRB_FIELD_RESET;
            uart2_transmit_level <= `IPRB_FIELD_RESET;
            uart2_receive_level <= `IPRB_FIELD_RESET;
            ext_irq2_level <= `IPRB_FIELD_RESET;
            timer5_level <= `IPRB_FIELD_RESET;
            spi2_event_level <= `IPRB_FIELD_RESET;
            spi2_fault_level <= `IPRB_FIELD_RESET;
            capture5_level <= `IPRB_FIELD_RESET;
            capture4_level <= `IPRB_FIELD_RESET;
            capture3_level <= `IPRB_FIELD_RESET;
            compare5_level <= `IPRB_FIELD_RESET;
            parallel_port_level <= `IPRB_FIELD_RESET;
            source_active <= 15'h7FFF;
        end else if (clk_en) begin
            ext_irq1_level <= fld_level[2:0];
            timer4_level <= fld_level[5:3];
            compare4_level <= fld_level[8:6];
            compare3_level <= fld_level[11:9];
            uart2_transmit_level <= fld_level[14:12];
            uart2_receive_level <= fld_level[17:15];
            ext_irq2_level <= fld_level[20:18];
            timer5_level <= fld_level[23:21];
            spi2_event_level <= fld_level[26:24];
            spi2_fault_level <= fld_level[29:27];
            capture5_level <= fld_level[32:30];
            capture4_level <= fld_level[35:33];
            capture3_level <= fld_level[38:36];
            compare5_level <= fld_level[41:39];
            parallel_port_level <= fld_level[44:42];
            source_active <= fld_active[14:0];
        end
    end
endmodule

// ==== design/iprb_consts.vh ====
// register offsets, field positions, reset value and disable value of the priority bank
// Functional notes
// - field value is the binary priority level, 7 highest, 1 lowest
// - field value 000 disables the source; it is never eligible
// - level 1 is the lowest enabled level, outranked by all higher
// - bits without a field ignore writes and read as zero
// - every field resets to 100 (level 4) and is read/write
// - ext irq1 field at bits 2-0, bits 15-3 unused
// - timer4 14-12, compare4 10-8, compare3 6-4
// - uart2 tx 14-12, uart2 rx 10-8, ext irq2 6-4, timer5 2-0
// - spi2 event 6-4, spi2 fault 2-0, bits 15-7 unused
// - capture5 14-12, capture4 10-8, capture3 6-4, bits 3-0 unused
// - compare5 field at bits 6-4, all else unused
// - parallel port field at bits 6-4, all else unused
`ifndef IPRB_CONSTS_VH
`define IPRB_CONSTS_VH
`define IPRB_OFS_EXT1 12'h000
`define IPRB_OFS_TMR4 12'h004
`define IPRB_OFS_UART2 12'h008
`define IPRB_OFS_SPI2 12'h00C
`define IPRB_OFS_CAP 12'h010
`define IPRB_OFS_CMP5 12'h014
`define IPRB_OFS_PMP 12'h018
`define IPRB_POS_HI 12
`define IPRB_POS_MH 8
`define IPRB_POS_ML 4
`define IPRB_POS_LO 0
`define IPRB_FIELD_RESET 3'h4
`define IPRB_FIELD_OFF 3'h0
`endif

// ==== design/iprb_field.v ====
// one 3-bit priority field with reset value and enable decode
`timescale 1ns/1ps
`include "iprb_consts.vh"
module iprb_field (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // write side
    input wire wr_en,
    input wire [2:0] wr_data,
    // level out
    output reg [2:0] level_q,
    output reg active_q
);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= `IPRB_FIELD_RESET;
            active_q <= 1'b1;
        end else if (clk_en && wr_en) begin
            level_q <= wr_data;
            active_q <= (wr_data != `IPRB_FIELD_OFF);
        end
    end
endmodule

// ==== tb/iprb_bank_monitor.sv ====
// concurrent checks on the priority bank ports
`timescale 1ns/1ps
module iprb_bank_monitor (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // bus side
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    // levels
    input wire [2:0] ext_irq1_level,
    input wire [2:0] parallel_port_level,
    input wire [14:0] source_active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence req(logic w, logic [9:0] a);
        hsel && hready && htrans[1] && clk_en && hwrite == w && haddr[11:2] == a;
    endsequence
    // write to the first register, clock enabled through its data phase and field update
    sequence wr_held;
        req(1'b1, 10'h0) ##1 clk_en [*2];
    endsequence
    a_unused_zero: assert property (
        hrdata[31:15] == 17'h0 && !hrdata[11] && !hrdata[7] && !hrdata[3])
        else $error("unused read bits not zero");
    a_ext1_width: assert property (req(1'b0, 10'h0) |=> hrdata[15:3] == 13'h0)
        else $error("ext irq1 register has bits above 2");
    a_spi2_width: assert property (req(1'b0, 10'h3) |=> hrdata[15:7] == 9'h0)
        else $error("spi2 register has bits above 6");
    a_cap_low: assert property (req(1'b0, 10'h4) |=> hrdata[3:0] == 4'h0)
        else $error("capture register low nibble not zero");
    a_cmp5_bits: assert property (
        req(1'b0, 10'h5) |=> hrdata[15:7] == 9'h0 && hrdata[3:0] == 4'h0)
        else $error("compare5 register unused bits set");
    a_pmp_bits: assert property (
        req(1'b0, 10'h6) |=> hrdata[15:7] == 9'h0 && hrdata[3:0] == 4'h0)
        else $error("parallel port register unused bits set");
    a_write_level: assert property (
        wr_held |=> ext_irq1_level == $past(hwdata[2:0], 2))
        else $error("ext irq1 level does not follow written value");
    a_reset_level: assert property ($rose(hresetn) |-> ext_irq1_level == 3'h4 &&
        parallel_port_level == 3'h4 && source_active == 15'h7FFF)
        else $error("levels not at reset value");
    a_active_map: assert property (source_active[0] == (ext_irq1_level != 3'h0) &&
        source_active[14] == (parallel_port_level != 3'h0))
        else $error("active flag disagrees with level");
endmodule
bind iprb_bank iprb_bank_monitor iprb_bank_monitor_i (.hclk, .hresetn, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .ext_irq1_level, .parallel_port_level,
    .source_active);

// ==== tb/iprb_bank_tb_top.sv ====
// self-checking bench for the priority bank
`timescale 1ns/1ps
module iprb_bank_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rd;
    logic rs;
    wire hresp;
    wire hready;
    wire [31:0] hrdata;
    wire [44:0] lv;
    wire [14:0] act;
    int n_errors = 0, comparisons = 0;
    logic [15:0] rst_v [7] = '{16'h4, 16'h4440, 16'h4444, 16'h44, 16'h4440, 16'h40, 16'h40};
    logic [15:0] pw [7] = '{16'h1, 16'h5670, 16'h1234, 16'h2, 16'h3210, 16'h7F, 16'hFFF0};
    logic [15:0] pe [7] = '{16'h1, 16'h5670, 16'h1234, 16'h2, 16'h3210, 16'h70, 16'h70};
    iprb_bank iprb_bank_i (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
        .ext_irq1_level(lv[44:42]), .timer4_level(lv[41:39]), .compare4_level(lv[38:36]),
        .compare3_level(lv[35:33]), .uart2_transmit_level(lv[32:30]),
        .uart2_receive_level(lv[29:27]), .ext_irq2_level(lv[26:24]), .timer5_level(lv[23:21]),
        .spi2_event_level(lv[20:18]), .spi2_fault_level(lv[17:15]), .capture5_level(lv[14:12]),
        .capture4_level(lv[11:9]), .capture3_level(lv[8:6]), .compare5_level(lv[5:3]),
        .parallel_port_level(lv[2:0]), .source_active(act));
    always #12.5 hclk = ~hclk;
    // one single word transfer; read data kept in rd
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        rs = hresp;
    endtask
    task automatic chk(input string what, input logic [44:0] exp, input logic [44:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk("read data", e, rd);
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        chk("levels", {15{3'h4}}, lv);
        chk("active", 15'h7FFF, act);
        for (int i = 0; i < 7; i++) begin
            rdchk(12'(i * 4), rst_v[i]);
            xfer(1'b1, 12'(i * 4), 32'hFFFFFFFF);
            rdchk(12'(i * 4), (rst_v[i] >> 2) * 7);
        end
        xfer(1'b1, 12'h01C, 32'hFFFFFFFF);
        chk("response", 45'h0, rs);
        rdchk(12'h01C, 32'h0);
        chk("levels", {15{3'h7}}, lv);
        for (int i = 0; i < 7; i++) xfer(1'b1, 12'(i * 4), 32'h0);
        repeat (2) @(posedge hclk);
        chk("levels", 45'h0, lv);
        chk("active", 15'h0, act);
        for (int i = 0; i < 7; i++) xfer(1'b1, 12'(i * 4), pw[i]);
        for (int i = 0; i < 7; i++) rdchk(12'(i * 4), pe[i]);
        chk("levels", 45'h6EE5381347F, lv);
        chk("active", 15'h7EFF, act);
        // with the clock enable low the request must not be taken
        clk_en <= 1'b0;
        xfer(1'b1, 12'h000, 32'h6);
        clk_en <= 1'b1;
        rdchk(12'h000, 32'h1);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        test_done;
    end
endmodule
